// File: rtl/eph_pkg.sv
// shared constants and types of the probe startup and supervision block
package eph_pkg;
    localparam int CLK_PERIOD_NS        = 50;
    localparam int PROBE_RESET_DELAY_NS = 800;
    localparam int DET_DELAY_SHORT_NS   = 2000;
    localparam int DET_DELAY_EXT_NS     = 30000;
    localparam int FLASH_HALF_MS        = 250;

    // least time rounded up to whole cycles, never below one
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CNT_W  = 10;
    localparam int PAT_W  = 4;
    localparam int MBX_W  = 16;
    localparam int POLL_W = 16;
    localparam int FILT_W = 16;
    localparam int BLNK_W = 28;

    localparam logic [CNT_W-1:0] RESET_DELAY_CYC =
        CNT_W'(min_cycles(PROBE_RESET_DELAY_NS));
    localparam logic [CNT_W-1:0] DET_SHORT_CYC = CNT_W'(min_cycles(DET_DELAY_SHORT_NS));
    localparam logic [CNT_W-1:0] DET_EXT_CYC   = CNT_W'(min_cycles(DET_DELAY_EXT_NS));
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (1000000 / CLK_PERIOD_NS);
    localparam int POLL_CYC_DEF   = 100;
    localparam int FILTER_CYC_DEF = 20;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;

    typedef enum logic { MODE_TRACE, MODE_DEBUG } eph_mode_t;
    typedef enum logic [1:0] { S_RESET, S_DELAY, S_INIT, S_RUN } eph_state_t;
endpackage

// File: rtl/eph_level_filter.sv
// level filter: output follows the input once it has been stable long enough
`timescale 1ns/1ps
module eph_level_filter #(
    parameter int CYC = eph_pkg::FILTER_CYC_DEF
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic level_in,
    output logic      level_out
);
    import eph_pkg::*;

    typedef struct packed {
        logic [FILT_W-1:0] cnt;
        logic              q;
    } eph_filt_t;

    eph_filt_t r_reg;
    eph_filt_t r_next;

    always_comb begin
        r_next = r_reg;
        if (level_in == r_reg.q) begin
            r_next.cnt = '0;
        end else if (r_reg.cnt >= FILT_W'(CYC - 1)) begin
            r_next.q   = level_in;
            r_next.cnt = '0;
        end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign level_out = r_reg.q;
endmodule

// File: rtl/eph_blinker.sv
// square wave for the flashing led, low while disabled
`timescale 1ns/1ps
module eph_blinker #(
    parameter int HALF = eph_pkg::FLASH_HALF_CYC
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic en,
    output logic      blink
);
    import eph_pkg::*;

    typedef struct packed {
        logic [BLNK_W-1:0] cnt;
        logic              q;
    } eph_blink_t;

    eph_blink_t r_reg;
    eph_blink_t r_next;

    always_comb begin
        r_next = r_reg;
        if (!en) begin
            r_next = '0;
        end else if (r_reg.cnt >= BLNK_W'(HALF - 1)) begin
            r_next.cnt = '0;
            r_next.q   = ~r_reg.q;
        end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign blink = r_reg.q;
endmodule

// File: rtl/eph_probe_core.sv
// probe supervision, status leds, startup handshake and page control
`timescale 1ns/1ps
module eph_probe_core #(
    parameter int FLASH_HALF = eph_pkg::FLASH_HALF_CYC,
    parameter int POLL_CYC   = eph_pkg::POLL_CYC_DEF,
    parameter int FILTER_CYC = eph_pkg::FILTER_CYC_DEF
) (
    input  wire logic                       core_clk,
    input  wire logic                       resetn,
    input  wire logic                       ecu_supply_sense,
    input  wire logic                       ecu_standby_sense,
    input  wire logic                       host_ready,
    input  wire logic                       host_link_up,
    input  wire logic                       host_init_done,
    input  wire logic                       host_download_done,
    input  wire logic                       host_reset_req,
    input  wire logic                       host_page_req,
    input  wire logic                       boot_config_mode,
    input  wire eph_pkg::eph_mode_t         port_mode,
    input  wire logic                       ext_delay_sel,
    input  wire logic [eph_pkg::PAT_W-1:0]  pattern_fail,
    input  wire logic [eph_pkg::PAT_W-1:0]  pattern_ok,
    input  wire logic [eph_pkg::MBX_W-1:0]  ack_value,
    input  wire logic                       ecu_reset_line_in,
    output logic                            ecu_reset_line_out,
    output logic                            ecu_reset_line_oe_n,
    output logic [eph_pkg::PAT_W-1:0]       aux_data_lines_out,
    output logic                            aux_data_lines_oe_n,
    output logic                            mbx_rd_req,
    input  wire logic                       mbx_rd_ack,
    input  wire logic [eph_pkg::MBX_W-1:0]  mbx_rd_data,
    input  wire logic                       probe_detect_line_in,
    output logic                            probe_detect_line_out,
    output logic                            probe_detect_line_oe_n,
    output logic                            probe_detect_pullup_en,
    input  wire logic                       standby_fail_line_in,
    output logic                            standby_fail_line_out,
    output logic                            standby_fail_line_oe_n,
    output logic                            standby_fail_pullup_en,
    input  wire logic [1:0]                 acquisition_trigger_lines,
    output logic                            led_red,
    output logic                            led_green,
    output logic                            led_yellow,
    output logic                            ecu_on,
    output logic                            ram_valid,
    output logic                            ecu_present,
    output logic                            meas_enable,
    output logic                            page_working,
    output logic                            mem_access_ok,
    output logic                            ref_access_ok,
    output logic [eph_pkg::MBX_W-1:0]       trig_event
);
    import eph_pkg::*;

    typedef struct packed {
        eph_state_t        st;
        logic [CNT_W-1:0]  cnt;
        logic [POLL_W-1:0] poll;
        logic              pend;
        logic              req;
        logic              pf;
        logic              stby_q;
        logic              armed;
        logic              boot;
        logic              present;
        logic              pg;
        logic              rst_drv;
        logic [3:0]        lines_q;
        logic [MBX_W-1:0]  trig;
    } eph_core_t;

    eph_core_t r_reg;
    eph_core_t r_next;

    logic standby_ok;
    logic ecu_running;
    logic poll_en;
    logic blink;
    logic [3:0] lines;

    eph_level_filter #(.CYC(FILTER_CYC)) u_supply_filt (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .level_in  (ecu_supply_sense),
        .level_out (ecu_on)
    );

    eph_level_filter #(.CYC(FILTER_CYC)) u_standby_filt (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .level_in  (ecu_standby_sense),
        .level_out (standby_ok)
    );

    eph_blinker #(.HALF(FLASH_HALF)) u_blink (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (r_reg.boot),
        .blink    (blink)
    );

    // all four trigger lines, active low
    assign lines = {acquisition_trigger_lines, standby_fail_line_in,
                    probe_detect_line_in};
    assign ecu_running   = ecu_on && ecu_reset_line_in;
    assign mem_access_ok = ecu_running && (r_reg.st == S_INIT || r_reg.st == S_RUN);
    assign poll_en       = mem_access_ok && (port_mode == MODE_TRACE);

    always_comb begin
        r_next         = r_reg;
        r_next.req     = 1'b0;
        r_next.trig    = '0;
        r_next.lines_q = lines;
        r_next.armed   = 1'b1;
        // the strap is caught on the first clock after reset release
        if (!r_reg.armed) begin
            r_next.boot = boot_config_mode;
        end else if (host_init_done) begin
            r_next.boot = 1'b0;
        end
        // only a loss seen while monitoring counts: the filter reads low until it
        // settles, so a standby supply absent from power up is not flagged
        // a new failure wins over a download finishing in the same cycle
        r_next.stby_q = standby_ok;
        if (r_reg.stby_q && !standby_ok) begin
            r_next.pf = 1'b1;
        end else if (host_download_done) begin
            r_next.pf = 1'b0;
        end
        r_next.pg      = host_page_req && !r_next.pf && (r_reg.st == S_RUN);
        r_next.rst_drv = !ecu_on || host_reset_req;
        if (poll_en && !r_reg.pend) begin
            if (r_reg.poll == '0) begin
                r_next.req  = 1'b1;
                r_next.pend = 1'b1;
                r_next.poll = POLL_W'(POLL_CYC - 1);
            end else begin
                r_next.poll = r_reg.poll - 1'b1;
            end
        end
        if (mbx_rd_ack) begin
            r_next.pend = 1'b0;
        end
        unique case (r_reg.st)
            S_RESET: begin
                r_next.present = 1'b0;
                if (ecu_running) begin
                    r_next.st = S_DELAY;
                    if (port_mode == MODE_DEBUG) begin
                        r_next.cnt = RESET_DELAY_CYC;
                    end else begin
                        r_next.cnt = ext_delay_sel ? DET_EXT_CYC : DET_SHORT_CYC;
                    end
                end
            end
            S_DELAY: begin
                if (r_reg.cnt <= CNT_W'(1)) begin
                    r_next.st  = S_INIT;
                    r_next.cnt = CNT_RST;
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            S_INIT: begin
                if (port_mode == MODE_TRACE) begin
                    if (mbx_rd_ack && mbx_rd_data == ack_value) begin
                        r_next.st      = S_RUN;
                        r_next.present = 1'b1;
                    end
                end else if (probe_detect_line_in && standby_fail_line_in) begin
                    r_next.st      = S_RUN;
                    r_next.present = 1'b1;
                end
            end
            S_RUN: begin
                if (port_mode == MODE_TRACE) begin
                    // the pattern latch is never consulted here, only the mailbox
                    if (mbx_rd_ack && mbx_rd_data != ack_value) begin
                        r_next.trig = mbx_rd_data;
                    end
                end else begin
                    r_next.trig = MBX_W'(r_reg.lines_q & ~lines);
                end
            end
        endcase
        if (!ecu_running) begin
            r_next.st      = S_RESET;
            r_next.pend    = 1'b0;
            r_next.present = 1'b0;
            r_next.poll    = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            r_reg         <= '0;
            r_reg.st      <= S_RESET;
            r_reg.cnt     <= CNT_RST;
            r_reg.rst_drv <= 1'b1;
            r_reg.lines_q <= 4'hf;
        end else begin
            r_reg <= r_next;
        end
    end

    // open drain reset: only ever pulls low
    assign ecu_reset_line_out  = 1'b0;
    assign ecu_reset_line_oe_n = !r_reg.rst_drv;

    // pattern stays applied through reset and the detection delay after it
    assign aux_data_lines_out  = r_reg.pf ? pattern_fail : pattern_ok;
    assign aux_data_lines_oe_n = !(port_mode == MODE_TRACE &&
                                   (r_reg.st == S_RESET || r_reg.st == S_DELAY));

    assign probe_detect_line_out  = 1'b0;
    assign probe_detect_line_oe_n = !(port_mode == MODE_DEBUG && r_reg.st == S_INIT);
    assign probe_detect_pullup_en = port_mode == MODE_DEBUG &&
                                    (r_reg.st == S_RESET || r_reg.st == S_DELAY);
    assign standby_fail_line_out  = 1'b0;
    assign standby_fail_line_oe_n = !(port_mode == MODE_DEBUG && r_reg.st == S_INIT &&
                                      !r_reg.pf);
    assign standby_fail_pullup_en = port_mode == MODE_DEBUG &&
                                    (r_reg.st == S_RESET || r_reg.st == S_DELAY ||
                                     (r_reg.st == S_INIT && r_reg.pf));

    assign led_red     = ecu_on || host_ready;
    assign led_green   = r_reg.pf ? 1'b1 : blink;
    assign led_yellow  = host_link_up;
    assign ram_valid   = !r_reg.pf;
    assign ecu_present = r_reg.present;
    assign meas_enable = r_reg.present && !r_reg.boot;
    assign page_working  = r_reg.pg;
    assign ref_access_ok = mem_access_ok && !r_reg.pg;
    // gated so that no request leaves in the cycle the ecu stops
    assign mbx_rd_req  = r_reg.req && ecu_running;
    assign trig_event  = r_reg.trig;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_red_led_on: assert property (ecu_on |-> led_red)
        else $error("red led dark while ecu on");
    a_green_steady_pf: assert property ($fell(standby_ok) |=> led_green && !ram_valid)
        else $error("green led not lit after standby loss");
    a_pf_forces_ref: assert property (r_reg.pf |-> !page_working)
        else $error("working page selected after power fail");
    a_boot_refuse: assert property (r_reg.boot |-> !meas_enable &&
        led_green == (r_reg.pf || blink))
        else $error("measurement enabled in boot mode");
    a_yellow_link: assert property (led_yellow == host_link_up)
        else $error("yellow led does not follow link");
    a_no_mem_reset: assert property (mbx_rd_req |-> ecu_running && $past(ecu_running))
        else $error("mailbox read while ecu not running");
    a_ref_access_gate: assert property (ref_access_ok |-> !page_working && ecu_running)
        else $error("reference access while working page active");
    a_pattern_reset: assert property ((port_mode == MODE_TRACE && r_reg.st == S_RESET)
        |-> !aux_data_lines_oe_n && aux_data_lines_out == (r_reg.pf ? pattern_fail
        : pattern_ok))
        else $error("detection pattern missing in reset");
    a_debug_delay_hold: assert property (($rose(r_reg.st == S_DELAY) &&
        port_mode == MODE_DEBUG && $stable(port_mode)) |-> probe_detect_line_oe_n[*8])
        else $error("detect pulled before reset delay");
    a_detect_pull_init: assert property ((port_mode == MODE_DEBUG && r_reg.st == S_INIT)
        |-> !probe_detect_line_oe_n && !probe_detect_pullup_en)
        else $error("detect not pulled low in init");
    a_fail_line_init: assert property ((port_mode == MODE_DEBUG && r_reg.st == S_INIT)
        |-> standby_fail_line_oe_n == r_reg.pf && standby_fail_pullup_en == r_reg.pf)
        else $error("fail line does not match power fail state in init");
    a_release_pulls: assert property ((port_mode == MODE_DEBUG && r_reg.st == S_RUN)
        |-> probe_detect_line_oe_n && standby_fail_line_oe_n)
        else $error("pulldowns kept after ecu init done");
    a_ack_present: assert property ((r_reg.st == S_INIT && port_mode == MODE_TRACE &&
        ecu_running && mbx_rd_ack && mbx_rd_data == ack_value) |=> ecu_present)
        else $error("acknowledge did not report presence");
    a_reset_drive: assert property (host_reset_req |=> !ecu_reset_line_oe_n)
        else $error("ecu reset not driven on host request");

    c_trace_present: cover property (port_mode == MODE_TRACE && $rose(ecu_present));
    c_debug_present: cover property (port_mode == MODE_DEBUG && $rose(ecu_present));
    c_trigger_seen: cover property (ecu_present && trig_event != '0);
    c_pf_cleared: cover property ($fell(r_reg.pf));
    c_pf_set: cover property ($rose(r_reg.pf));
endmodule

// File: verification/eph_ecu_model.sv
// behavioural ecu: reset pin, pattern latch, mailbox and trigger pins
`timescale 1ns/1ps
module eph_ecu_model #(
    parameter int INIT_CYC = 30
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        trace,
    input  wire logic        rst_out,
    input  wire logic        rst_oe_n,
    output logic             rst_in,
    input  wire logic [3:0]  aux,
    output logic [3:0]       lpat,
    input  wire logic [15:0] ack,
    input  wire logic [15:0] rast,
    input  wire logic        r_stb,
    input  wire logic [1:0]  t_idx,
    input  wire logic        t_stb,
    input  wire logic        det_out,
    input  wire logic        det_oe_n,
    output logic             det_in,
    input  wire logic        fl_out,
    input  wire logic        fl_oe_n,
    input  wire logic        fl_pu,
    output logic             fl_in,
    output logic [1:0]       acq,
    input  wire logic        mbx_req,
    output logic             mbx_ack,
    output logic [15:0]      mbx_d
);
    logic        rst_q, drv, pend, fl_q;
    logic [15:0] mbx;
    logic [9:0]  cnt;
    logic [1:0]  lat, low_cnt;
    logic [3:0]  low;
    assign rst_in = rst_oe_n ? 1'b1 : rst_out;
    // ecu pins win over the probe pulls once they are outputs
    assign det_in = drv ? !low[0] : (det_oe_n ? 1'b1 : det_out);
    // an unpulled fail line wanders, so nothing may rely on its last level
    assign fl_in  = drv ? !low[1] : (!fl_oe_n ? fl_out : (fl_pu ? 1'b1 : !fl_q));
    assign acq    = drv ? ~low[3:2] : 2'b11;
    always_ff @(posedge core_clk) begin
        rst_q   <= rst_in;
        fl_q    <= fl_in;
        mbx_ack <= 1'b0;
        mbx_d   <= ~mbx_d;
        if (rst_in && !rst_q) begin
            lpat <= aux;
        end
        if (!resetn || !rst_in) begin
            cnt     <= '0;
            drv     <= 1'b0;
            mbx     <= '0;
            pend    <= 1'b0;
            low     <= '0;
            low_cnt <= '0;
            mbx_d   <= 16'ha5a5;
        end else begin
            if (cnt != 10'(INIT_CYC)) begin
                cnt <= cnt + 10'h001;
            end
            if (cnt == 10'(INIT_CYC - 1)) begin
                if (trace) begin
                    mbx <= ack;
                end else begin
                    drv <= 1'b1;
                end
            end
            if (mbx_req && !pend) begin
                pend <= 1'b1;
                lat  <= 2'($urandom_range(2, 0));
            end
            if (pend && lat != 2'h0) begin
                lat <= lat - 2'h1;
            end else if (pend) begin
                pend    <= 1'b0;
                mbx_ack <= 1'b1;
                mbx_d   <= mbx;
                // a raster value is consumed by the read that returns it
                if (cnt == 10'(INIT_CYC)) begin
                    mbx <= ack;
                end
            end
            if (r_stb) begin
                mbx <= rast;
            end
            if (t_stb) begin
                low     <= 4'h1 << t_idx;
                low_cnt <= 2'h3;
            end else if (low_cnt != 2'h0) begin
                low_cnt <= low_cnt - 2'h1;
            end else begin
                low <= '0;
            end
        end
    end
    // overlay registers are left alone here after the handshake
endmodule

// File: verification/tb_ecu_probe_startup_handshake.sv
// self-checking bench for the probe supervision and startup core
`timescale 1ns/1ps
module tb_ecu_probe_startup_handshake;
    import eph_pkg::*;
    logic        core_clk, resetn, sup, stby, hrdy, hlink, hinit, hdl, hrst, hpage, boot, ext;
    eph_mode_t   mode;
    logic [3:0]  pat_f, pat_ok, aux, lpat;
    logic [15:0] ack, mbx_d, trig_ev, rast;
    logic        rst_in, rst_out, rst_oe_n, aux_oe_n, mbx_req, mbx_ack, r_stb, t_stb;
    logic        det_in, det_out, det_oe_n, det_pu, fl_in, fl_out, fl_oe_n, fl_pu;
    logic [1:0]  acq, t_idx;
    logic        red, green, yellow, ecu_on, ram_ok, present, meas_en, pg_w, mem_ok, ref_ok;
    int          num_errors, check_count, i, n, chg;

    eph_probe_core #(.FLASH_HALF(4), .POLL_CYC(4), .FILTER_CYC(2)) DUT (
        .core_clk(core_clk), .resetn(resetn), .ecu_supply_sense(sup), .ecu_standby_sense(stby),
        .host_ready(hrdy), .host_link_up(hlink), .host_init_done(hinit),
        .host_download_done(hdl), .host_reset_req(hrst), .host_page_req(hpage),
        .boot_config_mode(boot), .port_mode(mode), .ext_delay_sel(ext), .pattern_fail(pat_f),
        .pattern_ok(pat_ok), .ack_value(ack), .ecu_reset_line_in(rst_in),
        .ecu_reset_line_out(rst_out), .ecu_reset_line_oe_n(rst_oe_n), .aux_data_lines_out(aux),
        .aux_data_lines_oe_n(aux_oe_n), .mbx_rd_req(mbx_req), .mbx_rd_ack(mbx_ack),
        .mbx_rd_data(mbx_d), .probe_detect_line_in(det_in), .probe_detect_line_out(det_out),
        .probe_detect_line_oe_n(det_oe_n), .probe_detect_pullup_en(det_pu),
        .standby_fail_line_in(fl_in), .standby_fail_line_out(fl_out),
        .standby_fail_line_oe_n(fl_oe_n), .standby_fail_pullup_en(fl_pu),
        .acquisition_trigger_lines(acq), .led_red(red), .led_green(green), .led_yellow(yellow),
        .ecu_on(ecu_on), .ram_valid(ram_ok), .ecu_present(present), .meas_enable(meas_en),
        .page_working(pg_w), .mem_access_ok(mem_ok), .ref_access_ok(ref_ok), .trig_event(trig_ev)
    );
    eph_ecu_model ECU (
        .core_clk(core_clk), .resetn(resetn), .trace(mode == MODE_TRACE), .rst_out(rst_out),
        .rst_oe_n(rst_oe_n), .rst_in(rst_in), .aux(aux), .lpat(lpat), .ack(ack), .rast(rast),
        .r_stb(r_stb), .t_idx(t_idx), .t_stb(t_stb), .det_out(det_out), .det_oe_n(det_oe_n),
        .det_in(det_in), .fl_out(fl_out), .fl_oe_n(fl_oe_n), .fl_pu(fl_pu), .fl_in(fl_in),
        .acq(acq), .mbx_req(mbx_req), .mbx_ack(mbx_ack), .mbx_d(mbx_d)
    );

    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    function automatic logic cond(input int sel);
        case (sel)
            0: return rst_in === 1'b1;
            1: return aux_oe_n === 1'b1;
            2: return det_oe_n === 1'b0;
            3: return present === 1'b1;
            default: return trig_ev !== 16'h0000;
        endcase
    endfunction
    // a bound that runs out ends the run as a failure
    task automatic wait_for(input int sel, input int lim);
        for (n = 0; n < lim && !cond(sel); n++) @(negedge core_clk);
        if (!cond(sel)) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    function automatic int exp_delay();
        if (mode == MODE_DEBUG) return int'(RESET_DELAY_CYC);
        return ext ? int'(DET_EXT_CYC) : int'(DET_SHORT_CYC);
    endfunction
    task automatic toggles();
        logic prev;
        chg = 0;
        prev = green;
        repeat (20) begin
            @(negedge core_clk);
            chg += int'(green !== prev);
            prev = green;
        end
    endtask
    task automatic startup(input logic pf);
        tick(2);
        if (mode == MODE_TRACE) begin
            check({aux_oe_n, aux}, {1'b0, pf ? pat_f : pat_ok});
        end else begin
            check({det_pu, fl_pu, det_oe_n, fl_oe_n}, 4'hf);
        end
        hrst = 1'b0;
        sup = 1'b1;
        wait_for(0, 60);
        wait_for(mode == MODE_TRACE ? 1 : 2, 700);
        check(n >= exp_delay() && n <= exp_delay() + 3, 1'b1);
        if (mode == MODE_TRACE) begin
            check(lpat, pf ? pat_f : pat_ok);
        end else begin
            check({det_in, fl_in}, {1'b0, pf});
        end
        wait_for(3, 300);
        check({ecu_on, mem_ok, det_oe_n | (mode == MODE_TRACE)}, 3'h7);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(negedge core_clk) if (mbx_req === 1'b1) check(mem_ok, 1'b1);

    initial begin
        num_errors = 0;
        check_count = 0;
        n = $urandom(32'he454acc6);
        {resetn, sup, stby, hrdy, hlink, hinit, hdl, hrst, hpage, boot, ext} = 11'h102;
        {r_stb, t_stb, t_idx} = 4'h0;
        mode = MODE_DEBUG;
        pat_f = 4'($urandom);
        pat_ok = ~pat_f;
        ack = {1'b0, 15'($urandom)};
        rast = 16'h0000;
        tick(2);
        resetn = 1'b1;
        tick(2);
        check({rst_oe_n, ecu_on, mem_ok, present}, 4'h0);
        for (i = 0; i < 8; i++) begin
            {hrdy, hlink} = 2'($urandom);
            tick(1);
            check({red, yellow}, {hrdy, hlink});
        end
        hrdy = 1'b0;
        toggles();
        check(chg >= 4, 1'b1);
        startup(1'b0);
        check({meas_en, red}, 2'b01);
        hinit = 1'b1;
        tick(1);
        hinit = 1'b0;
        tick(1);
        toggles();
        check({chg != 0, green, meas_en}, 3'h1);
        for (i = 0; i < 4; i++) begin
            t_idx = 2'(i);
            t_stb = 1'b1;
            tick(1);
            t_stb = 1'b0;
            wait_for(4, 8);
            check(trig_ev, 16'h0001 << i);
            tick(4);
        end
        hrst = 1'b1;
        tick(3);
        check({rst_oe_n, present}, 2'b00);
        stby = 1'b0;
        tick(4);
        stby = 1'b1;
        hpage = 1'b1;
        tick(3);
        check({ram_ok, green}, 2'b01);
        mode = MODE_TRACE;
        startup(1'b1);
        check({meas_en, ram_ok, green, pg_w}, 4'ha);
        hdl = 1'b1;
        tick(1);
        hdl = 1'b0;
        tick(3);
        check({ram_ok, green, pg_w, ref_ok}, 4'ha);
        hpage = 1'b0;
        tick(3);
        check({pg_w, ref_ok}, 2'b01);
        for (i = 0; i < 3; i++) begin
            rast = {1'b1, 15'($urandom)};
            r_stb = 1'b1;
            tick(1);
            r_stb = 1'b0;
            wait_for(4, 40);
            check(trig_ev, rast);
        end
        sup = 1'b0;
        tick(6);
        check({ecu_on, present, mem_ok, rst_oe_n}, 4'h0);
        ext = 1'b1;
        startup(1'b0);
        tally_and_finish();
    end
endmodule
